// *** nio_map.svh ***
`ifndef NIO_MAP_SVH
`define NIO_MAP_SVH

// Clock and carrier timing
`define NIO_CLK_HZ            100_000_000
`define NIO_IR_CARRIER_HZ     38_500
`define NIO_IR_HALF_CYCLES    (`NIO_CLK_HZ / (2 * `NIO_IR_CARRIER_HZ))
`define NIO_IR_CNT_W          11

// Mode control field positions
`define NIO_MODE_IR_EN_BIT    3
`define NIO_MODE_IR_SEL_BIT   1

// Pin index map: one [3:0], two [7:4], three [11:8], six [15:12]
`define NIO_PORT_TWO_B3       7
`define NIO_PORT_THREE_B3     11
`define NIO_PORT_THREE_LSB    8

// Reset values
`define NIO_PIN_RST           16'h0000
`define NIO_PWM_CNT_RST       8'h00

`endif

// *** nio_pkg.sv ***
package nio_pkg;

    typedef logic [7:0]  nio_duty_t;
    typedef logic [15:0] nio_pins_t;

    typedef enum {
        NIO_RUN,
        NIO_STOP
    } nio_state_e;

endpackage

// *** nio_pwm_if.sv ***
`timescale 1ns/1ps
interface nio_pwm_if;
    logic [3:0]        en;
    nio_pkg::nio_duty_t duty [4];
    logic [3:0]        pwm;

    modport gen (
        input  en,
        input  duty,
        output pwm
    );
    modport user (
        output en,
        output duty,
        input  pwm
    );
endinterface

// *** nio_pwm.sv ***
`timescale 1ns/1ps
`include "nio_map.svh"
module nio_pwm (
    input  wire logic clk,
    input  wire logic clk_en,
    input  wire logic rst_b,
    nio_pwm_if.gen    pwm_bus
);

    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [3:0] pwm_reg;
    logic [3:0] pwm_next;

    assign pwm_bus.pwm = pwm_reg;

    always_comb begin
        cnt_next = cnt_reg + 8'h01;
    end

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_ch
            always_comb begin
                pwm_next[i] = pwm_bus.en[i] && (cnt_reg < pwm_bus.duty[i]);
            end

            a_pwm_duty_match: assert property (
                @(posedge clk) disable iff (!rst_b)
                clk_en |=> pwm_reg[i] == ($past(pwm_bus.en[i])
                    && ($past(cnt_reg) < $past(pwm_bus.duty[i]))))
                else $error("pwm level does not follow duty compare");
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= `NIO_PWM_CNT_RST;
            pwm_reg <= 4'h0;
        end else if (clk_en) begin
            cnt_reg <= cnt_next;
            pwm_reg <= pwm_next;
        end
    end

    a_pwm_count_step: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en |=> cnt_reg == 8'($past(cnt_reg) + 8'h01))
        else $error("pwm period counter did not advance");

endmodule

// *** nio_port.sv ***
`timescale 1ns/1ps
`include "nio_map.svh"
// Notes on behaviour
// - Four nibble ports, per-pin input or output
// - Halt request gates system clock off
// - Any pin edge while stopped wakes
// - Mode bit three enables infrared carrier
// - Port-three bit-three gated by 38.5 kHz carrier, output on port-three bit-three, or port-two bit-three with mode bit one
// - Port-three pins carry four pulse-width outputs
// - Resistor select picks external or internal resistor
module nio_port (
    input  wire logic             clk,
    input  wire logic             clk_en,
    input  wire logic             rst_b,
    input  wire nio_pkg::nio_pins_t pin_in,
    output nio_pkg::nio_pins_t    pin_out,
    output nio_pkg::nio_pins_t    pin_oe,
    output nio_pkg::nio_pins_t    pin_pull_dn,
    output nio_pkg::nio_pins_t    port_read,
    input  wire nio_pkg::nio_pins_t port_dir,
    input  wire nio_pkg::nio_pins_t port_data,
    input  wire logic [3:0]       mode_ctrl,
    input  wire logic [3:0]       pwm_en,
    input  wire logic [31:0]      pwm_duty,
    input  wire logic             halt_req,
    output logic                  sys_clk_run,
    input  wire logic             osc_resistor_select,
    output logic                  osc_ext_resistor_en
);

    nio_pkg::nio_state_e state_reg;
    nio_pkg::nio_state_e state_next;
    nio_pkg::nio_pins_t  pin_prev_reg;
    nio_pkg::nio_pins_t  pin_out_reg;
    nio_pkg::nio_pins_t  pin_out_next;
    nio_pkg::nio_pins_t  pin_oe_reg;
    nio_pkg::nio_pins_t  pin_pull_dn_reg;
    nio_pkg::nio_pins_t  port_read_reg;
    logic [`NIO_IR_CNT_W-1:0] car_cnt_reg;
    logic [`NIO_IR_CNT_W-1:0] car_cnt_next;
    logic                carrier_reg;
    logic                carrier_next;
    logic                osc_sel_reg;
    logic                ir_en;
    logic                ir_sel;
    logic                ir_mod;

    localparam logic [`NIO_IR_CNT_W-1:0] CAR_LAST =
        `NIO_IR_CNT_W'(`NIO_IR_HALF_CYCLES - 1);

    nio_pwm_if pwm_bus ();

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_duty
            assign pwm_bus.duty[k] = pwm_duty[8*k +: 8];
        end
    endgenerate
    assign pwm_bus.en = pwm_en;

    nio_pwm u_pwm (
        .clk     (clk),
        .clk_en  (clk_en),
        .rst_b   (rst_b),
        .pwm_bus (pwm_bus)
    );

    assign pin_out             = pin_out_reg;
    assign pin_oe              = pin_oe_reg;
    assign pin_pull_dn         = pin_pull_dn_reg;
    assign port_read           = port_read_reg;
    assign osc_ext_resistor_en = osc_sel_reg;
    // core clock runs only in run state
    assign sys_clk_run = (state_reg == nio_pkg::NIO_RUN);

    // halt enters stop; any edge wakes
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            nio_pkg::NIO_RUN: begin
                if (halt_req) begin
                    state_next = nio_pkg::NIO_STOP;
                end
            end
            nio_pkg::NIO_STOP: begin
                if (pin_in != pin_prev_reg) begin
                    state_next = nio_pkg::NIO_RUN;
                end
            end
            default: begin
                state_next = nio_pkg::NIO_RUN;
            end
        endcase
    end

    // square carrier, toggles each half period
    always_comb begin
        car_cnt_next = car_cnt_reg + `NIO_IR_CNT_W'(1);
        carrier_next = carrier_reg;
        if (car_cnt_reg == CAR_LAST) begin
            car_cnt_next = '0;
            carrier_next = ~carrier_reg;
        end
    end

    assign ir_en  = mode_ctrl[`NIO_MODE_IR_EN_BIT];
    assign ir_sel = mode_ctrl[`NIO_MODE_IR_SEL_BIT];
    assign ir_mod = port_data[`NIO_PORT_THREE_B3] & carrier_reg;

    // Infrared overrides pulse width on port-three bit three
    always_comb begin
        pin_out_next = port_data;
        for (int i = 0; i < 4; i++) begin
            if (pwm_en[i]) begin
                pin_out_next[`NIO_PORT_THREE_LSB + i] = pwm_bus.pwm[i];
            end
        end
        // route modulated bit by pin select
        if (ir_en) begin
            if (ir_sel) begin
                pin_out_next[`NIO_PORT_TWO_B3] = ir_mod;
            end else begin
                pin_out_next[`NIO_PORT_THREE_B3] = ir_mod;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg       <= nio_pkg::NIO_RUN;
            pin_prev_reg    <= `NIO_PIN_RST;
            pin_out_reg     <= `NIO_PIN_RST;
            pin_oe_reg      <= `NIO_PIN_RST;
            pin_pull_dn_reg <= `NIO_PIN_RST;
            port_read_reg   <= `NIO_PIN_RST;
            car_cnt_reg     <= '0;
            carrier_reg     <= 1'b0;
            osc_sel_reg     <= 1'b0;
        end else if (clk_en) begin
            state_reg       <= state_next;
            pin_prev_reg    <= pin_in;
            pin_out_reg     <= pin_out_next;
            pin_oe_reg      <= port_dir;
            pin_pull_dn_reg <= ~port_dir;
            port_read_reg   <= pin_in;
            car_cnt_reg     <= car_cnt_next;
            carrier_reg     <= carrier_next;
            // resistor select follows the strap pin
            osc_sel_reg     <= osc_resistor_select;
        end
    end

    a_dir_pull_oe: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en |=> (pin_oe == $past(port_dir))
            && (pin_pull_dn == ~pin_oe))
        else $error("pin direction or pull-down wrong");

    a_halt_stop: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en && sys_clk_run && halt_req |=> !sys_clk_run)
        else $error("halt did not stop the clock");

    a_stop_wake: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en && !sys_clk_run && (pin_in != pin_prev_reg)
            |=> sys_clk_run)
        else $error("pin edge did not wake from stop");

    a_stop_hold: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en && !sys_clk_run && (pin_in == pin_prev_reg)
            |=> !sys_clk_run)
        else $error("left stop with no pin edge");

    a_carrier_half: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en && (car_cnt_reg == CAR_LAST)
            |=> (carrier_reg != $past(carrier_reg)) && (car_cnt_reg == 0))
        else $error("carrier half period wrong");

    a_ir_route_two: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en && ir_en && ir_sel |=> pin_out[`NIO_PORT_TWO_B3]
            == ($past(port_data[`NIO_PORT_THREE_B3]) & $past(carrier_reg)))
        else $error("infrared not on port two bit three");

    a_ir_route_three: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en && ir_en && !ir_sel |=> pin_out[`NIO_PORT_THREE_B3]
            == ($past(port_data[`NIO_PORT_THREE_B3]) & $past(carrier_reg)))
        else $error("infrared not on port three bit three");

    a_ir_off_plain: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en && !ir_en |=> pin_out[`NIO_PORT_TWO_B3]
            == $past(port_data[`NIO_PORT_TWO_B3]))
        else $error("port two bit three altered with infrared off");

    a_osc_select: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en |=> osc_ext_resistor_en == $past(osc_resistor_select))
        else $error("oscillator resistor select not followed");

    a_read_follow: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en |=> port_read == $past(pin_in))
        else $error("port read value does not follow pins");

    a_pwm_pin_mux: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en && pwm_en[0] |=> pin_out[`NIO_PORT_THREE_LSB]
            == $past(pwm_bus.pwm[0]))
        else $error("pulse width not on port three bit zero");

    a_carrier_count: assert property (
        @(posedge clk) disable iff (!rst_b)
        clk_en && (car_cnt_reg != CAR_LAST)
            |=> (car_cnt_reg == $past(car_cnt_reg) + `NIO_IR_CNT_W'(1))
            && $stable(carrier_reg))
        else $error("carrier count or level wrong mid half period");

    a_en_freeze: assert property (
        @(posedge clk) disable iff (!rst_b)
        !clk_en |=> $stable(sys_clk_run) && $stable(pin_out)
            && $stable(osc_ext_resistor_en))
        else $error("state changed while clock enable low");

endmodule

// *** nio_pin_model.sv ***
`timescale 1ns/1ps
module nio_pin_model (
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    input  wire logic [15:0] pin_pull_dn,
    input  wire logic [15:0] key_val,
    input  wire logic [15:0] key_en,
    output logic      [15:0] pin_level
);
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pin_oe[i]) begin
                pin_level[i] = pin_out[i];
            end else if (key_en[i]) begin
                pin_level[i] = key_val[i];
            end else if (pin_pull_dn[i]) begin
                pin_level[i] = 1'h0;
            end else begin
                // Floating pin must not look settled
                pin_level[i] = ~pin_out[i];
            end
        end
    end
endmodule

// *** tb_nibble_io_ir_pwm_wakeup.sv ***
`timescale 1ns/1ps
module tb_nibble_io_ir_pwm_wakeup;
    logic        clk = 1'h0;
    logic        clk_en = 1'h1;
    logic        rst_b = 1'h0;
    logic [15:0] pin_in;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic [15:0] pin_pull_dn;
    logic [15:0] port_read;
    logic [15:0] port_dir = 16'h0000;
    logic [15:0] port_data = 16'h0000;
    logic [15:0] key_val = 16'h0000;
    logic [15:0] key_en = 16'h0000;
    logic [3:0]  mode_ctrl = 4'h0;
    logic [3:0]  pwm_en = 4'h0;
    logic [31:0] pwm_duty = 32'h0000_0000;
    logic        halt_req = 1'h0;
    logic        sys_clk_run;
    logic        osc_sel = 1'h0;
    logic        osc_ext;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #5 clk = ~clk;

    nio_port u_dut (.clk(clk), .clk_en(clk_en), .rst_b(rst_b),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_dn(pin_pull_dn), .port_read(port_read),
        .port_dir(port_dir), .port_data(port_data),
        .mode_ctrl(mode_ctrl), .pwm_en(pwm_en), .pwm_duty(pwm_duty),
        .halt_req(halt_req), .sys_clk_run(sys_clk_run),
        .osc_resistor_select(osc_sel), .osc_ext_resistor_en(osc_ext));

    nio_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_dn(pin_pull_dn), .key_val(key_val), .key_en(key_en),
        .pin_level(pin_in));

    task automatic end_of_test;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Cycles until pin idx changes, capped
    task automatic measure(input int idx, output int n);
        logic v;
        v = pin_out[idx];
        n = 0;
        while (pin_out[idx] === v && n < 3000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_dir;
        port_dir = 16'h5A3C;
        port_data = 16'hF0F0;
        key_en = 16'hFFFF;
        key_val = 16'h9669;
        step(2);
        check("pin_oe", pin_oe, 16'h5A3C);
        check("pull_dn", pin_pull_dn, 16'hA5C3);
        check("pin_out", pin_out & 16'h5A3C, 16'h5030);
        check("read", port_read, 16'h5030 | (16'h9669 & 16'hA5C3));
        key_en = 16'h0000;
        step(2);
        check("read_pulled", port_read, 16'h5030);
    endtask

    task automatic t_halt(input logic lvl);
        port_dir = 16'h0000;
        key_en = 16'hFFFF;
        key_val = {16{lvl}};
        step(3);
        halt_req = 1'h1;
        step(1);
        halt_req = 1'h0;
        check("run_stop", 16'(sys_clk_run), 16'h0000);
        step(3);
        check("run_hold", 16'(sys_clk_run), 16'h0000);
        key_val[13] = ~lvl;
        step(1);
        check("run_wake", 16'(sys_clk_run), 16'h0001);
    endtask

    task automatic t_ir;
        int n;
        key_en = 16'h0000;
        port_dir = 16'h0880;
        port_data = 16'h0800;
        mode_ctrl = 4'h8;
        measure(11, n);
        measure(11, n);
        check("ir_half", 16'(n), 16'h0512);
        check("two_plain", 16'(pin_out[7]), 16'h0000);
        port_data = 16'h0000;
        measure(11, n);
        measure(11, n);
        check("ir_gated", 16'(n), 16'h0BB8);
        mode_ctrl = 4'hA;
        port_data = 16'h0800;
        measure(7, n);
        measure(7, n);
        check("ir_two", 16'(n), 16'h0512);
        check("three_plain", 16'(pin_out[11]), 16'h0001);
        mode_ctrl = 4'h0;
        step(2);
        measure(7, n);
        check("ir_off", 16'(n), 16'h0BB8);
    endtask

    task automatic t_pwm;
        int hi[4];
        hi = '{0, 0, 0, 0};
        port_dir = 16'h0F00;
        pwm_duty = 32'hFF80_0100;
        pwm_en = 4'hF;
        step(4);
        repeat (256) begin
            @(negedge clk);
            for (int i = 0; i < 4; i++) hi[i] += int'(pin_out[8 + i]);
        end
        for (int i = 0; i < 4; i++) begin
            check("pwm_high", 16'(hi[i]), 16'(pwm_duty[8*i +: 8]));
        end
        pwm_en = 4'h0;
        port_data = 16'h0A00;
        step(3);
        check("pwm_off", 16'(pin_out[11:8]), 16'h000A);
    endtask

    task automatic t_osc;
        osc_sel = 1'h1;
        step(2);
        check("osc_ext", 16'(osc_ext), 16'h0001);
        osc_sel = 1'h0;
        step(2);
        check("osc_int", 16'(osc_ext), 16'h0000);
    endtask

    // Enable low must freeze run state, pin outputs and resistor select
    task automatic t_freeze;
        clk_en = 1'h0;
        osc_sel = 1'h1;
        port_data = 16'h0F0F;
        halt_req = 1'h1;
        step(3);
        check("frz_osc", 16'(osc_ext), 16'h0000);
        check("frz_out", pin_out, 16'h0A00);
        check("frz_run", 16'(sys_clk_run), 16'h0001);
        halt_req = 1'h0;
        osc_sel = 1'h0;
        clk_en = 1'h1;
        step(2);
        check("frz_go", pin_out, 16'h0F0F);
    endtask

    // Hang guard, well above the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        step(6);
        rst_b = 1'h1;
        step(2);
        t_dir();
        t_halt(1'h0);
        t_halt(1'h1);
        t_ir();
        t_pwm();
        t_osc();
        t_freeze();
        end_of_test();
    end
endmodule
